// [hdl/vic_ctrl.sv]
// Vectored IRQ priority controller: decoder, handshake machine, nesting
// How it works
// - Decoder always evaluates pending channels; winner loads vector, requests IRQ.
// - Line to core is internal request ORed with inverted output enable.
// - Each channel has 4-bit priority, 0 lowest, 15 highest.
// - Equal priority ties go to the larger channel number.
// - 32 enable and pending bits; pending sets only while enabled.
// - Winner is pending, above current priority, outranks all others.
// - Current priority clears at reset; writes below source priority ignored.
// - Machine has ready and wait; reset to ready; new winner enters wait.
// - Leaves wait only on vector read or controller reset (soft bit 14).
// - Vector read in wait returns to ready; no state status bit.
// - Nesting stack holds 15 entries of channel and priority.
// - Read in wait sets flag; next clock pushes old, loads new.
// - Read in ready sets no flag and leaves stack untouched.
// - Only strictly higher priority preempts; priority 0 never wins.
// - Pop only when pending bit of current channel is cleared.
// - Arbitration never halts; read returns highest pending at that moment.
// - Writing 1 clears a pending bit; writing 0 leaves it.
// - Pending re-sets while the peripheral request persists.
`default_nettype none
module vic_ctrl
  import vic_pkg::*;
#(
  parameter int NCH   = NUM_CH,
  parameter int DEPTH = STACK_D
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   softResetKeepN,
  input  wire logic                   irqOutEnable,
  input  wire logic [NCH-1:0]         srcRequest,
  input  wire logic [NCH-1:0]         channelEnable,
  input  wire logic [NCH-1:0]         pendingClearWr,
  input  wire logic [NCH*PRIO_W-1:0]  sourcePriority,
  input  wire logic [NCH*VEC_W-1:0]   routineAddr,
  input  wire logic                   curPrioWr,
  input  wire logic [PRIO_W-1:0]      curPrioWrData,
  input  wire logic                   vectorRead,
  output logic                        irqRequestN,
  output logic [VEC_W-1:0]            vectorOut,
  output logic [NCH-1:0]              pendingOut,
  output logic [CH_W-1:0]             currentChannel,
  output logic [PRIO_W-1:0]           currentPriority
);
  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  initial begin
    if (NCH < 2 || NCH > 32) $error("vic_ctrl: NCH must be 2..32");
    if (DEPTH < 1 || DEPTH > 15) $error("vic_ctrl: DEPTH must be 1..15");
  end

  // ----------------------------------------------------------------------
  // Controller reset: global reset or soft reset bit held clear
  // ----------------------------------------------------------------------
  logic [2:0] swSync_q;
  logic       swResetN_q;
  wire        ctrlReset = reset || !swResetN_q;

  // Soft reset bit arrives from another block; filtered by 3-stage sync
  always_ff @(posedge mclk) begin
    if (reset) begin
      swSync_q   <= 3'h7;
      swResetN_q <= 1'b1;
    end else begin
      swSync_q <= {swSync_q[1:0], softResetKeepN};
      if (swSync_q[1] == swSync_q[2]) begin
        swResetN_q <= swSync_q[2];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Priority field access
  // ----------------------------------------------------------------------
  function automatic logic [PRIO_W-1:0] prioOf(input int ch,
      input logic [NCH*PRIO_W-1:0] tbl);
    prioOf = tbl[ch*PRIO_W +: PRIO_W];
  endfunction : prioOf

  // ----------------------------------------------------------------------
  // Pending bits
  // ----------------------------------------------------------------------
  logic [NCH-1:0] pend_q;
  logic [NCH-1:0] pend_d;

  // Set beats clear, so a request arriving with a clear is kept
  assign pend_d = (pend_q & ~pendingClearWr)
                | (srcRequest & channelEnable);

  always_ff @(posedge mclk) begin
    if (ctrlReset) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end
  assign pendingOut = pend_q;

  // ----------------------------------------------------------------------
  // Priority decoder: purely combinational, never halted
  // ----------------------------------------------------------------------
  logic [PRIO_W-1:0] curPrio_q;
  logic [CH_W-1:0]   curCh_q;
  logic              haveWinner;
  logic [CH_W-1:0]   winCh;
  logic [PRIO_W-1:0] winPrio;

  // Ascending scan with >= lets the higher channel take a tie
  always_comb begin
    haveWinner = 1'b0;
    winCh      = CH_RST;
    winPrio    = curPrio_q;
    for (int i = 0; i < NCH; i++) begin
      if (pend_q[i] && prioOf(i, sourcePriority) > curPrio_q
          && (!haveWinner || prioOf(i, sourcePriority) >= winPrio)) begin
        haveWinner = 1'b1;
        winCh      = CH_W'(i);
        winPrio    = prioOf(i, sourcePriority);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Vector register follows the winner while one exists
  // ----------------------------------------------------------------------
  logic [VEC_W-1:0] vec_q;
  logic [CH_W-1:0]  vecCh_q;
  wire  [VEC_W-1:0] winAddr = routineAddr[winCh*VEC_W +: VEC_W];

  always_ff @(posedge mclk) begin
    if (ctrlReset) begin
      vec_q   <= VEC_RST;
      vecCh_q <= CH_RST;
    end else if (haveWinner) begin
      vec_q   <= winAddr;
      vecCh_q <= winCh;
    end
  end
  assign vectorOut = vec_q;

  // ----------------------------------------------------------------------
  // Handshake machine
  // ----------------------------------------------------------------------
  vic_state_t state_q;
  vic_state_t state_d;
  logic       ackFlag_q;
  wire        ackInWait = vectorRead && (state_q == VIC_WAIT);

  always_comb begin
    state_d = state_q;
    case (state_q)
      VIC_READY: begin
        // Push cycle still shows the old current priority; without the
        // flag gate the channel just acknowledged would request again
        if (haveWinner && !ackFlag_q) begin
          state_d = VIC_WAIT;
        end
      end
      VIC_WAIT: begin
        if (vectorRead) begin
          state_d = VIC_READY;
        end
      end
      default: state_d = VIC_READY;
    endcase
  end

  // Read in ready raises no flag; read in wait flags one push cycle
  always_ff @(posedge mclk) begin
    if (ctrlReset) begin
      state_q   <= VIC_READY;
      ackFlag_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      ackFlag_q <= ackInWait;
    end
  end

  // Request pin is masked by the output enable, never by the machine
  assign irqRequestN = (state_q != VIC_WAIT) || !irqOutEnable;

  // ----------------------------------------------------------------------
  // Nesting stack and current channel / priority
  // ----------------------------------------------------------------------
  vic_stack_if sif ();

  vic_stack #(
    .DEPTH (DEPTH)
  ) u_stack (
    .mclk (mclk),
    .rst  (ctrlReset),
    .sif  (sif)
  );

  // Channel captured at the read, so late winners cannot alter it
  logic [CH_W-1:0]  ackCh_q;
  always_ff @(posedge mclk) begin
    if (ctrlReset) begin
      ackCh_q <= CH_RST;
    end else if (ackInWait) begin
      ackCh_q <= vecCh_q;
    end
  end

  wire [PRIO_W-1:0] ackPrio  = prioOf(int'(ackCh_q), sourcePriority);
  wire              curClear = pendingClearWr[curCh_q] && !sif.empty
                             && !ackFlag_q;
  wire [PRIO_W-1:0] minPrio  = prioOf(int'(curCh_q), sourcePriority);
  wire              prioWrOk = curPrioWr && curPrioWrData >= minPrio;

  assign sif.push     = ackFlag_q;
  assign sif.pushCh   = curCh_q;
  assign sif.pushPrio = curPrio_q;
  assign sif.pop      = curClear;

  // Push takes priority; pop restores the previous routine's context
  always_ff @(posedge mclk) begin
    if (ctrlReset) begin
      curCh_q   <= CH_RST;
      curPrio_q <= PRIO_RST;
    end else if (ackFlag_q) begin
      curCh_q   <= ackCh_q;
      curPrio_q <= ackPrio;
    end else if (curClear) begin
      curCh_q   <= sif.topCh;
      curPrio_q <= sif.topPrio;
    end else if (prioWrOk) begin
      curPrio_q <= curPrioWrData;
    end
  end

  assign currentChannel  = curCh_q;
  assign currentPriority = curPrio_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  line_mask_a: assert property (@(posedge mclk) disable iff (reset)
      !irqOutEnable |-> irqRequestN)
    else $error("IRQ line low while output disabled");

  enter_wait_a: assert property (@(posedge mclk) disable iff (ctrlReset)
      (state_q == VIC_READY && haveWinner && !ackFlag_q)
      |=> state_q == VIC_WAIT)
    else $error("Winner did not move machine to wait");

  hold_wait_a: assert property (@(posedge mclk) disable iff (ctrlReset)
      (state_q == VIC_WAIT && !vectorRead) |=> state_q == VIC_WAIT)
    else $error("Wait left without a vector read");

  read_ready_a: assert property (@(posedge mclk) disable iff (ctrlReset)
      (state_q == VIC_WAIT && vectorRead) |=> state_q == VIC_READY)
    else $error("Vector read in wait did not release line");

  push_next_a: assert property (@(posedge mclk) disable iff (ctrlReset)
      (state_q == VIC_WAIT && vectorRead) |=> sif.push ##1
      (curCh_q == $past(ackCh_q)))
    else $error("Push or channel load missed after read");

  no_flag_a: assert property (@(posedge mclk) disable iff (ctrlReset)
      (state_q == VIC_READY && vectorRead) |=> !ackFlag_q)
    else $error("Read in ready raised the flag");

  win_above_a: assert property (@(posedge mclk) disable iff (ctrlReset)
      haveWinner |-> (winPrio > curPrio_q && winPrio != 4'h0))
    else $error("Winner not above current priority");

  pend_enable_a: assert property (@(posedge mclk) disable iff (ctrlReset)
      ($rose(pend_q[0]) |-> $past(channelEnable[0])))
    else $error("Pending set on a disabled channel");

  pop_only_a: assert property (@(posedge mclk) disable iff (ctrlReset)
      sif.pop |-> pendingClearWr[curCh_q])
    else $error("Stack popped without clear of current");

  prio_low_a: assert property (@(posedge mclk) disable iff (ctrlReset)
      (curPrioWr && curPrioWrData < minPrio && !ackFlag_q && !curClear)
      |=> curPrio_q == $past(curPrio_q))
    else $error("Low current priority write took effect");
endmodule : vic_ctrl
`default_nettype wire

// [hdl/vic_pkg.sv]
// Package: constants and types for the vectored IRQ priority controller
`default_nettype none
package vic_pkg;
  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_CH     = 32;
  localparam int CH_W       = 5;
  localparam int PRIO_W     = 4;
  localparam int STACK_D    = 15;
  localparam int VEC_W      = 16;
  localparam int SWRES_BIT  = 14;
  localparam logic [PRIO_W-1:0] PRIO_MAX  = 4'hF;
  localparam logic [PRIO_W-1:0] PRIO_RST  = 4'h0;
  localparam logic [CH_W-1:0]   CH_RST    = 5'h00;
  localparam logic [VEC_W-1:0]  VEC_RST   = 16'h0000;

  // ----------------------------------------------------------------------
  // Handshake machine states
  // ----------------------------------------------------------------------
  typedef enum logic {VIC_READY, VIC_WAIT} vic_state_t;
endpackage : vic_pkg
`default_nettype wire

// [hdl/vic_stack_if.sv]
// Interface: push/pop carrier between controller and nesting stack
`default_nettype none
interface vic_stack_if;
  import vic_pkg::*;
  logic                push;
  logic                pop;
  logic [CH_W-1:0]     pushCh;
  logic [PRIO_W-1:0]   pushPrio;
  logic [CH_W-1:0]     topCh;
  logic [PRIO_W-1:0]   topPrio;
  logic                empty;
  modport ctrl  (output push, pop, pushCh, pushPrio,
                 input topCh, topPrio, empty);
  modport stack (input push, pop, pushCh, pushPrio,
                 output topCh, topPrio, empty);
endinterface : vic_stack_if
`default_nettype wire

// [hdl/vic_stack.sv]
// Nesting stack holding saved channel and priority pairs
`default_nettype none
module vic_stack
  import vic_pkg::*;
#(
  parameter int DEPTH = STACK_D
) (
  input  wire logic  mclk,
  input  wire logic  rst,
  vic_stack_if.stack sif
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  initial begin
    if (DEPTH < 1 || DEPTH > 15) $error("vic_stack: DEPTH out of range");
  end
  logic [CH_W-1:0]   chMem   [DEPTH];
  logic [PRIO_W-1:0] prMem   [DEPTH];
  logic [3:0]        level_q;
  wire  [3:0]        topIdx = level_q - 4'h1;

  assign sif.empty   = (level_q == 4'h0);
  assign sif.topCh   = sif.empty ? CH_RST : chMem[topIdx];
  assign sif.topPrio = sif.empty ? PRIO_RST : prMem[topIdx];

  // Depth counter; a push onto a full stack is dropped to keep state sane
  always_ff @(posedge mclk) begin
    if (rst) begin
      level_q <= 4'h0;
    end else if (sif.push && level_q != 4'(DEPTH)) begin
      level_q <= level_q + 4'h1;
    end else if (sif.pop && !sif.empty) begin
      level_q <= level_q - 4'h1;
    end
  end

  // Entry write
  always_ff @(posedge mclk) begin
    if (sif.push && level_q != 4'(DEPTH)) begin
      chMem[level_q] <= sif.pushCh;
      prMem[level_q] <= sif.pushPrio;
    end
  end
endmodule : vic_stack
`default_nettype wire

// [bench/vic_core_model.sv]
// Core model: answers the active-low IRQ line with a vector read
`default_nettype none
module vic_core_model (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic serveEn,
  input  wire logic irqRequestN,
  output var  logic vectorRead
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // Acknowledge
  // ----------------------------------------------------------------------
  logic armedQ;
  logic rdNow;
  initial begin
    vectorRead = 1'b0;
    armedQ     = 1'b1;
  end
  // One read per request; re-arm only once the line has gone high again,
  // so a slow line release never yields a second acknowledge
  always @(posedge mclk) begin
    rdNow = serveEn && armedQ && !irqRequestN && !reset;
    if (reset || irqRequestN) begin
      armedQ <= 1'b1;
    end else if (rdNow) begin
      armedQ <= 1'b0;
    end
    vectorRead <= #1 rdNow;
  end
endmodule : vic_core_model
`default_nettype wire

// [bench/test_vectored_irq_priority_controller.sv]
// Testbench for the vectored IRQ priority controller
`default_nettype none
module test_vectored_irq_priority_controller;
  import vic_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int chA; int pA; int chB; int pB; bit enB; int win;}
    vic_row_t;
  logic mclk, reset, softResetKeepN, irqOutEnable, curPrioWr;
  logic tbRead, coreRead, serveEn, vectorRead, irqRequestN;
  logic [31:0] srcRequest, channelEnable, pendingClearWr, pendingOut;
  logic [127:0] sourcePriority;
  logic [511:0] routineAddr;
  logic [3:0]   curPrioWrData, currentPriority;
  logic [15:0]  vectorOut;
  logic [4:0]   currentChannel;
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  assign vectorRead = tbRead | coreRead;
  vic_ctrl vic_ctrl_inst (.mclk(mclk), .reset(reset),
    .softResetKeepN(softResetKeepN), .irqOutEnable(irqOutEnable),
    .srcRequest(srcRequest), .channelEnable(channelEnable),
    .pendingClearWr(pendingClearWr), .sourcePriority(sourcePriority),
    .routineAddr(routineAddr), .curPrioWr(curPrioWr),
    .curPrioWrData(curPrioWrData), .vectorRead(vectorRead),
    .irqRequestN(irqRequestN), .vectorOut(vectorOut),
    .pendingOut(pendingOut), .currentChannel(currentChannel),
    .currentPriority(currentPriority));
  vic_core_model vic_core_model_inst (.mclk(mclk), .reset(reset),
    .serveEn(serveEn), .irqRequestN(irqRequestN), .vectorRead(coreRead));
  // ----------------------------------------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Generous ceiling: the whole run needs under a hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  function automatic logic [15:0] addrOf(input int ch);
    return 16'hA000 | 16'(ch);
  endfunction : addrOf
  task automatic doReset();
    reset = 1'b1;
    srcRequest = '0;
    step(3);
    reset = 1'b0;
  endtask : doReset
  task automatic pulseReq(input logic [31:0] m);
    srcRequest = m;
    step(1);
    srcRequest = '0;
  endtask : pulseReq
  // Peripheral flag is low here except in the set-wins check, where the clear does not stick
  task automatic clr(input int ch);
    pendingClearWr = 32'h1 << ch;
    step(1);
    pendingClearWr = '0;
    step(1);
  endtask : clr
  task automatic serve(input int ch, input int p);
    tbRead = 1'b1;
    step(1);
    tbRead = 1'b0;
    check("line released", irqRequestN, 1);
    step(1);
    check("current channel", currentChannel, ch);
    check("current priority", currentPriority, p);
  endtask : serve
  task automatic setPrio(input int ch, input int p);
    sourcePriority[4*ch +: 4] = 4'(p);
  endtask : setPrio
  // ----------------------------------------------------------------------
  // Arbitration table: two requests, expected winner (-1 none)
  // ----------------------------------------------------------------------
  vic_row_t rows [5] = '{
    '{2, 5, 6, 5, 1, 6}, '{31, 3, 0, 9, 1, 0}, '{4, 0, 7, 0, 1, -1},
    '{1, 15, 30, 14, 1, 1}, '{9, 2, 10, 8, 0, 9}};
  initial begin
    {softResetKeepN, irqOutEnable, serveEn} = 3'b111;
    {curPrioWr, tbRead, curPrioWrData} = '0;
    {srcRequest, channelEnable, pendingClearWr} = '0;
    sourcePriority = '0;
    for (int i = 0; i < 32; i++) routineAddr[16*i +: 16] = addrOf(i);
    foreach (rows[r]) begin
      doReset();
      sourcePriority = '0;
      setPrio(rows[r].chA, rows[r].pA);
      setPrio(rows[r].chB, rows[r].pB);
      channelEnable = (32'h1 << rows[r].chA)
                    | (rows[r].enB ? 32'h1 << rows[r].chB : 32'h0);
      pulseReq((32'h1 << rows[r].chA) | (32'h1 << rows[r].chB));
      step(1);
      check("line", irqRequestN, rows[r].win < 0);
      check("vector", vectorOut,
            rows[r].win < 0 ? 16'h0000 : addrOf(rows[r].win));
      check("pending", pendingOut, channelEnable);
      if (rows[r].win >= 0) begin
        step(3);
        check("row channel", currentChannel, rows[r].win);
      end
      $display("row %0d done", r);
    end
    // Reset values, reads in ready, masking and soft reset
    serveEn = 1'b0;
    channelEnable = '1;
    doReset();
    check("reset line", irqRequestN, 1);
    check("reset prio", currentPriority, 0);
    check("reset pending", pendingOut, 0);
    tbRead = 1'b1;
    step(1);
    tbRead = 1'b0;
    step(1);
    check("ready read", {currentChannel, currentPriority}, 0);
    setPrio(3, 4);
    irqOutEnable = 1'b0;
    pulseReq(32'h8);
    step(1);
    check("masked line", irqRequestN, 1);
    irqOutEnable = 1'b1;
    #1;
    check("unmasked line", irqRequestN, 0);
    step(3);
    check("wait holds", irqRequestN, 0);
    softResetKeepN = 1'b0;
    step(5);
    check("soft reset line", irqRequestN, 1);
    check("soft reset pend", pendingOut, 0);
    softResetKeepN = 1'b1;
    step(5);
    $display("reset test done");
    // Nesting, late winner, priority writes and pops
    doReset();
    setPrio(8, 6);
    setPrio(12, 9);
    pulseReq(32'h8);
    step(1);
    check("first vector", vectorOut, addrOf(3));
    pulseReq(32'h100);
    step(1);
    check("late winner", vectorOut, addrOf(8));
    serve(8, 6);
    check("no preempt", irqRequestN, 1);
    irqOutEnable = 1'b0; // served pending bit is left alone
    curPrioWr = 1'b1;
    curPrioWrData = 4'h5;
    step(1);
    curPrioWrData = 4'h7;
    step(1);
    curPrioWr = 1'b0;
    irqOutEnable = 1'b1;
    step(1);
    check("prio write", currentPriority, 7);
    clr(3);
    check("other clear", currentChannel, 8);
    check("clear bits", pendingOut, 32'h100);
    pulseReq(32'h1000);
    step(1);
    serve(12, 9);
    // Clear with the peripheral still asking: pop, then a second run
    srcRequest = 32'h1000;
    clr(12);
    check("set wins", pendingOut[12], 1);
    check("pop on clear", currentChannel, 8);
    check("second run", irqRequestN, 0);
    srcRequest = '0;
    serve(12, 9);
    clr(12);
    check("pop", {currentChannel, currentPriority}, {5'h08, 4'h7});
    clr(8);
    check("main level", {currentChannel, currentPriority}, 0);
    $display("nesting test done");
    tally_and_finish();
  end
endmodule : test_vectored_irq_priority_controller
`default_nettype wire
